// [shared/adcwin_map.svh]
// register indices, field positions, reset values and timing counts
`ifndef ADCWIN_MAP_SVH
`define ADCWIN_MAP_SVH

// register indices, byte address is four times the index
`define ADCW_IDX_CTRL 10'h0c0
`define ADCW_IDX_STAT 10'h0c1
`define ADCW_IDX_IEN 10'h0c2
`define ADCW_IDX_ICLR 10'h0c3
`define ADCW_IDX_UP_LO 10'h0c4
`define ADCW_IDX_UP_HI 10'h0c5
`define ADCW_IDX_RES_LO 10'h0be
`define ADCW_IDX_RES_HI 10'h0bf
`define ADCW_IDX_LO_LO 10'h0c6
`define ADCW_IDX_LO_HI 10'h0c7

// control fields
`define ADCW_CTRL_ALIGN 0
`define ADCW_CTRL_SC_LSB 3
`define ADCW_CTRL_SC_MSB 7
// status, enable and clear fields
`define ADCW_ST_DONE 0
`define ADCW_ST_WIN 1

// reset values
`define ADCW_RST_BYTE 8'h00
`define ADCW_RST_SC 5'h1f
`define ADCW_RST_FLAGS 2'h0

// converter clocks per conversion
`define ADCW_SAR_CLKS 16
`endif

// [shared/adcwin_pkg.sv]
// types shared by the converter result and window logic
package adcwin_pkg;
   typedef logic [15:0] word_t;
   typedef logic [11:0] code_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01
   } conv_state_e;
endpackage

// [shared/win_cmp_if.sv]
// signals between the result logic and the window comparator
`timescale 1ns/10ps
interface win_cmp_if;
   adcwin_pkg::word_t result;
   adcwin_pkg::word_t upper;
   adcwin_pkg::word_t lower;
   logic is_signed;
   logic match;
   modport cmp (input result, input upper, input lower, input is_signed, output match);
   modport user (output result, output upper, output lower, output is_signed, input match);
endinterface

// [rtl/window_compare.sv]
// window comparator for one result word against two limits
`timescale 1ns/10ps
module window_compare (
   win_cmp_if.cmp bus
);
   logic gt_up;
   logic lt_lo;
   logic up_below_lo;

   // limits read in the same signedness as the result
   always_comb begin
      if (bus.is_signed) begin
         gt_up = $signed(bus.result) > $signed(bus.upper);
         lt_lo = $signed(bus.result) < $signed(bus.lower);
         up_below_lo = $signed(bus.upper) < $signed(bus.lower);
      end else begin
         gt_up = bus.result > bus.upper;
         lt_lo = bus.result < bus.lower;
         up_below_lo = bus.upper < bus.lower;
      end
   end

   // inside window when limits are ordered upper below lower, else outside
   assign bus.match = up_below_lo ? (gt_up & lt_lo) : (gt_up | lt_lo);
endmodule

// [rtl/adc_result_window_detect.sv]
// converter result formatting, window detect and apb register file
//
// Contract
// - the result is read through a high and a low byte register, both reset to zero.
// - right alignment puts the 12-bit code in high bits 3..0 and all of the low byte.
// - right-aligned high bits 7..4 copy bit 3 for differential results, else zero.
// - left alignment puts the code in the high byte and low bits 7..4, low 3..0 zero.
// - single-ended codes are unsigned and differential codes two's complement.
// - every new result is compared with both limits and a match sets the window flag.
// - the window flag is readable so software can poll it.
// - the limit ordering selects flagging inside or outside the window.
// - the lower limit low byte is a read/write register that resets to zero.
// - a conversion takes at least 16 converter clocks before results update.
// - the window flag stays set until software clears it.
// - one control bit selects alignment, 0 right and 1 left.
`timescale 1ns/10ps
`include "adcwin_map.svh"
module adc_result_window_detect #(
   parameter int SAR_CLKS = `ADCW_SAR_CLKS
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CONV_START,
   input wire logic CONV_DIFF,
   input wire logic [11:0] CONV_CODE,
   output logic CONV_BUSY,
   output logic WINDOW_MATCH,
   output logic IRQ
);
   if (SAR_CLKS < `ADCW_SAR_CLKS || SAR_CLKS > 255) begin : g_bad_clks
      $error("SAR_CLKS out of range");
   end

   localparam int MIN_CONV_CYC = 2 * SAR_CLKS;

   // apb decode
   logic setup;
   logic wr;
   logic [9:0] idx;
   logic hit;
   logic [7:0] wb;
   assign setup = PSEL & ~PENABLE;
   assign wr = PSEL & PENABLE & PWRITE & CE;
   assign idx = PADDR[11:2];
   assign wb = PWDATA[7:0];
   always_comb begin
      case (idx)
         `ADCW_IDX_CTRL, `ADCW_IDX_STAT, `ADCW_IDX_IEN, `ADCW_IDX_ICLR,
         `ADCW_IDX_UP_LO, `ADCW_IDX_UP_HI, `ADCW_IDX_RES_LO,
         `ADCW_IDX_RES_HI, `ADCW_IDX_LO_LO, `ADCW_IDX_LO_HI: hit = (PADDR[1:0] == 2'h0);
         default: hit = 1'b0;
      endcase
   end
   assign PREADY = CE;
   assign PSLVERR = PSEL & PENABLE & ~hit;

   // register state
   logic [7:0] res_lo_ff, nxt_res_lo;
   logic [7:0] res_hi_ff, nxt_res_hi;
   logic [7:0] up_lo_ff, nxt_up_lo;
   logic [7:0] up_hi_ff, nxt_up_hi;
   logic [7:0] lo_lo_ff, nxt_lo_lo;
   logic [7:0] lo_hi_ff, nxt_lo_hi;
   logic align_ff, nxt_align;
   logic [4:0] sc_ff, nxt_sc;
   logic [1:0] stat_ff, nxt_stat;
   logic [1:0] ien_ff, nxt_ien;
   logic [31:0] rdata_ff, nxt_rdata;

   // conversion state
   adcwin_pkg::conv_state_e st_ff, nxt_st;
   logic [5:0] div_ff, nxt_div;
   logic [7:0] sar_ff, nxt_sar;
   logic diff_ff, nxt_diff;
   logic tick;
   logic done;
   adcwin_pkg::word_t fmt;

   assign tick = (div_ff == {sc_ff, 1'b1});
   assign done = (st_ff == adcwin_pkg::ST_CONV) & tick & (sar_ff == 8'(SAR_CLKS - 1));

   always_comb begin
      nxt_st = st_ff;
      nxt_div = div_ff;
      nxt_sar = sar_ff;
      nxt_diff = diff_ff;
      case (st_ff)
         adcwin_pkg::ST_IDLE: begin
            nxt_div = 6'h00;
            nxt_sar = 8'h00;
            if (CONV_START) begin
               nxt_st = adcwin_pkg::ST_CONV;
               nxt_diff = CONV_DIFF;
            end
         end
         adcwin_pkg::ST_CONV: begin
            // converter clock is system clock over 2*(sc+1)
            nxt_div = tick ? 6'h00 : div_ff + 6'h01;
            if (tick) begin
               nxt_sar = sar_ff + 8'h01;
            end
            if (done) begin
               nxt_st = adcwin_pkg::ST_IDLE;
            end
         end
         default: nxt_st = adcwin_pkg::ST_IDLE;
      endcase
   end

   // result word in the selected alignment and sign format
   always_comb begin
      if (align_ff) begin
         fmt = {CONV_CODE, 4'h0};
      end else if (diff_ff) begin
         fmt = {{4{CONV_CODE[11]}}, CONV_CODE};
      end else begin
         fmt = {4'h0, CONV_CODE};
      end
   end

   // window comparator
   win_cmp_if wc ();
   assign wc.result = fmt;
   assign wc.upper = {up_hi_ff, up_lo_ff};
   assign wc.lower = {lo_hi_ff, lo_lo_ff};
   assign wc.is_signed = diff_ff;
   window_compare u_cmp (
      .bus(wc.cmp)
   );

   // register writes, hardware loads win over software
   always_comb begin
      nxt_res_lo = res_lo_ff;
      nxt_res_hi = res_hi_ff;
      nxt_up_lo = up_lo_ff;
      nxt_up_hi = up_hi_ff;
      nxt_lo_lo = lo_lo_ff;
      nxt_lo_hi = lo_hi_ff;
      nxt_align = align_ff;
      nxt_sc = sc_ff;
      nxt_stat = stat_ff;
      nxt_ien = ien_ff;
      if (wr) begin
         case (idx)
            `ADCW_IDX_CTRL: begin
               nxt_align = wb[`ADCW_CTRL_ALIGN];
               nxt_sc = wb[`ADCW_CTRL_SC_MSB:`ADCW_CTRL_SC_LSB];
            end
            `ADCW_IDX_IEN: nxt_ien = wb[1:0];
            `ADCW_IDX_ICLR: nxt_stat = stat_ff & ~wb[1:0];
            `ADCW_IDX_UP_LO: nxt_up_lo = wb;
            `ADCW_IDX_UP_HI: nxt_up_hi = wb;
            `ADCW_IDX_LO_LO: nxt_lo_lo = wb;
            `ADCW_IDX_LO_HI: nxt_lo_hi = wb;
            `ADCW_IDX_RES_LO: nxt_res_lo = wb;
            `ADCW_IDX_RES_HI: nxt_res_hi = wb;
            default: nxt_stat = stat_ff;
         endcase
      end
      if (done) begin
         nxt_res_hi = fmt[15:8];
         nxt_res_lo = fmt[7:0];
         nxt_stat[`ADCW_ST_DONE] = 1'b1;
         if (wc.match) begin
            nxt_stat[`ADCW_ST_WIN] = 1'b1;
         end
      end
   end

   // read data captured in the setup phase
   always_comb begin
      nxt_rdata = rdata_ff;
      if (setup) begin
         case (idx)
            `ADCW_IDX_CTRL: nxt_rdata = {24'h0, sc_ff, 2'h0, align_ff};
            `ADCW_IDX_STAT: nxt_rdata = {30'h0, stat_ff};
            `ADCW_IDX_IEN: nxt_rdata = {30'h0, ien_ff};
            `ADCW_IDX_UP_LO: nxt_rdata = {24'h0, up_lo_ff};
            `ADCW_IDX_UP_HI: nxt_rdata = {24'h0, up_hi_ff};
            `ADCW_IDX_LO_LO: nxt_rdata = {24'h0, lo_lo_ff};
            `ADCW_IDX_LO_HI: nxt_rdata = {24'h0, lo_hi_ff};
            `ADCW_IDX_RES_LO: nxt_rdata = {24'h0, res_lo_ff};
            `ADCW_IDX_RES_HI: nxt_rdata = {24'h0, res_hi_ff};
            default: nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         res_lo_ff <= `ADCW_RST_BYTE;
         res_hi_ff <= `ADCW_RST_BYTE;
         up_lo_ff <= `ADCW_RST_BYTE;
         up_hi_ff <= `ADCW_RST_BYTE;
         lo_lo_ff <= `ADCW_RST_BYTE;
         lo_hi_ff <= `ADCW_RST_BYTE;
         align_ff <= 1'b0;
         sc_ff <= `ADCW_RST_SC;
         stat_ff <= `ADCW_RST_FLAGS;
         ien_ff <= `ADCW_RST_FLAGS;
         rdata_ff <= 32'h0;
         st_ff <= adcwin_pkg::ST_IDLE;
         div_ff <= 6'h00;
         sar_ff <= 8'h00;
         diff_ff <= 1'b0;
      end else if (CE) begin
         res_lo_ff <= nxt_res_lo;
         res_hi_ff <= nxt_res_hi;
         up_lo_ff <= nxt_up_lo;
         up_hi_ff <= nxt_up_hi;
         lo_lo_ff <= nxt_lo_lo;
         lo_hi_ff <= nxt_lo_hi;
         align_ff <= nxt_align;
         sc_ff <= nxt_sc;
         stat_ff <= nxt_stat;
         ien_ff <= nxt_ien;
         rdata_ff <= nxt_rdata;
         st_ff <= nxt_st;
         div_ff <= nxt_div;
         sar_ff <= nxt_sar;
         diff_ff <= nxt_diff;
      end
   end

   assign PRDATA = rdata_ff;
   assign CONV_BUSY = (st_ff == adcwin_pkg::ST_CONV);
   assign WINDOW_MATCH = stat_ff[`ADCW_ST_WIN];
   assign IRQ = |(stat_ff & ien_ff);

   // cycles spent in the current conversion, for checking only
   logic [15:0] cyc_ff, nxt_cyc;
   always_comb begin
      nxt_cyc = CONV_BUSY ? cyc_ff + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cyc_ff <= 16'h0000;
      end else if (CE) begin
         cyc_ff <= nxt_cyc;
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   sequence s_load_right_se;
      CE && done && !align_ff && !diff_ff;
   endsequence
   sequence s_load_left;
      CE && done && align_ff;
   endsequence

   property p_reset_zero;
      disable iff (1'b0) RST |=> (res_hi_ff == 8'h00 && res_lo_ff == 8'h00 && lo_lo_ff == 8'h00);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("result bytes not zero after reset");

   property p_right_se;
      adcwin_pkg::code_t c;
      (s_load_right_se, c = CONV_CODE) |=> ({res_hi_ff, res_lo_ff} == {4'h0, c});
   endproperty
   a_right_se: assert property (p_right_se) else $error("right single-ended layout wrong");

   property p_right_diff;
      (CE && done && !align_ff && diff_ff) |=> (res_hi_ff[7:4] == {4{res_hi_ff[3]}});
   endproperty
   a_right_diff: assert property (p_right_diff) else $error("sign extension wrong");

   property p_left;
      adcwin_pkg::code_t c;
      (s_load_left, c = CONV_CODE) |=> ({res_hi_ff, res_lo_ff} == {c, 4'h0});
   endproperty
   a_left: assert property (p_left) else $error("left aligned layout wrong");

   property p_conv_time;
      (CE && done) |-> (cyc_ff >= 16'(MIN_CONV_CYC - 1));
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion finished too early");

   property p_flag_set;
      (CE && done && wc.match) |=> WINDOW_MATCH;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("window flag not set on match");

   property p_flag_sticky;
      (CE && WINDOW_MATCH && !(wr && idx == `ADCW_IDX_ICLR && wb[`ADCW_ST_WIN]))
         |=> WINDOW_MATCH;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("window flag lost");

   property p_poll;
      (CE && setup && idx == `ADCW_IDX_STAT) |=> (PRDATA[`ADCW_ST_WIN] == $past(WINDOW_MATCH));
   endproperty
   a_poll: assert property (p_poll) else $error("status read wrong flag");

   property p_inside;
      (CE && done && !diff_ff && wc.upper < wc.lower && fmt > wc.upper && fmt < wc.lower)
         |=> WINDOW_MATCH;
   endproperty
   a_inside: assert property (p_inside) else $error("inside window not flagged");

   property p_no_false;
      (CE && done && !diff_ff && wc.upper < wc.lower && fmt <= wc.upper && !WINDOW_MATCH
         && !(wr && idx == `ADCW_IDX_ICLR)) |=> !WINDOW_MATCH;
   endproperty
   a_no_false: assert property (p_no_false) else $error("flag set outside window");
endmodule

// [test/tb.sv]
// register-level testbench for the converter result and window detect block
`timescale 1ns/10ps
`include "adcwin_map.svh"
module tb;
   localparam logic [11:0] A_CTRL = {`ADCW_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_STAT = {`ADCW_IDX_STAT, 2'b00};
   localparam logic [11:0] A_IEN = {`ADCW_IDX_IEN, 2'b00};
   localparam logic [11:0] A_ICLR = {`ADCW_IDX_ICLR, 2'b00};
   localparam logic [11:0] A_UPLO = {`ADCW_IDX_UP_LO, 2'b00};
   localparam logic [11:0] A_UPHI = {`ADCW_IDX_UP_HI, 2'b00};
   localparam logic [11:0] A_RSLO = {`ADCW_IDX_RES_LO, 2'b00};
   localparam logic [11:0] A_RSHI = {`ADCW_IDX_RES_HI, 2'b00};
   localparam logic [11:0] A_LOLO = {`ADCW_IDX_LO_LO, 2'b00};
   localparam logic [11:0] A_LOHI = {`ADCW_IDX_LO_HI, 2'b00};
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic CE = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic CONV_START = 1'b0;
   logic CONV_DIFF = 1'b0;
   logic [11:0] CONV_CODE = 12'h000;
   logic CONV_BUSY;
   logic WINDOW_MATCH;
   logic IRQ;
   int err_count = 0;
   int comparisons = 0;
   logic [31:0] rd;
   logic er;
   int cyc;
   logic [15:0] w;
   logic m;
   // case table: diff, align, code, upper limit, lower limit
   logic cd [9] = '{0, 0, 0, 1, 0, 1, 1, 0, 0};
   logic ca [9] = '{0, 0, 0, 0, 1, 1, 0, 0, 0};
   logic [11:0] cc [9] = '{12'h800, 12'h900, 12'h050, 12'hfff, 12'h123, 12'h800, 12'h800,
      12'h400, 12'h100};
   logic [15:0] cu [9] = '{16'h0100, 16'h0100, 16'h0800, 16'hfff0, 16'h1000, 16'h1000, 16'h0000,
      16'h0800, 16'h0100};
   logic [15:0] cl [9] = '{16'h0900, 16'h0900, 16'h0100, 16'h0010, 16'h2000, 16'hc000, 16'h0000,
      16'h0100, 16'h0900};

   adc_result_window_detect dut (.CLOCK(CLOCK), .RST(RST), .CE(CE), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .CONV_START(CONV_START), .CONV_DIFF(CONV_DIFF),
      .CONV_CODE(CONV_CODE), .CONV_BUSY(CONV_BUSY), .WINDOW_MATCH(WINDOW_MATCH), .IRQ(IRQ));

   always #12.5 CLOCK = ~CLOCK;

   // expected register word for a code in the chosen format
   function automatic logic [15:0] fmt(input logic d, input logic al, input logic [11:0] c);
      if (al) begin
         return {c, 4'h0};
      end
      return {{4{d & c[11]}}, c};
   endfunction

   // expected window decision, strict compares, signed for differential
   function automatic logic hit(input logic d, input logic [15:0] v, input logic [15:0] u,
      input logic [15:0] l);
      logic signed [16:0] sv;
      logic signed [16:0] su;
      logic signed [16:0] sl;
      sv = d ? {v[15], v} : {1'b0, v};
      su = d ? {u[15], u} : {1'b0, u};
      sl = d ? {l[15], l} : {1'b0, l};
      if (su < sl) begin
         return (sv > su) && (sv < sl);
      end
      return (sv > su) || (sv < sl);
   endfunction

   task automatic report_and_stop();
      $display("errors=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      // only the watchdog ends a wait for ready
      do begin
         @(posedge CLOCK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // start held over two edges; the second falls while busy and must be ignored
   task automatic conv(input logic d, input logic [11:0] c);
      @(posedge CLOCK);
      CONV_START <= 1'b1;
      CONV_DIFF <= d;
      CONV_CODE <= c;
      repeat (2) @(posedge CLOCK);
      CONV_START <= 1'b0;
      cyc = 0;
      while (CONV_BUSY === 1'b1 && cyc < 2000) begin
         @(posedge CLOCK);
         cyc++;
      end
   endtask

   initial begin
      #(25.0 * 8000);
      err_count++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(posedge CLOCK);
      RST <= 1'b0;
      rchk(A_RSLO, 32'h0);
      rchk(A_RSHI, 32'h0);
      rchk(A_LOLO, 32'h0);
      rchk(A_CTRL, {24'h0, `ADCW_RST_SC, 3'h0});
      apb(1'b1, A_LOLO, 32'ha5);
      rchk(A_LOLO, 32'ha5);
      apb(1'b1, A_RSHI, 32'h5a);
      rchk(A_RSHI, 32'h5a);
      apb(1'b0, 12'hffc, 32'h0);
      chk({rd[30:0], er}, 32'h1); // unmapped read refused
      apb(1'b1, A_STAT, 32'hff);
      rchk(A_STAT, 32'h0);
      rchk(A_ICLR, 32'h0);
      apb(1'b1, A_IEN, 32'h1 << `ADCW_ST_WIN);
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, A_CTRL, {31'h0, ca[i]});
         apb(1'b1, A_UPLO, {24'h0, cu[i][7:0]});
         apb(1'b1, A_UPHI, {24'h0, cu[i][15:8]});
         apb(1'b1, A_LOLO, {24'h0, cl[i][7:0]});
         apb(1'b1, A_LOHI, {24'h0, cl[i][15:8]});
         apb(1'b1, A_ICLR, 32'h3);
         conv(cd[i], cc[i]);
         chk(cyc, `ADCW_SAR_CLKS * 2);
         w = fmt(cd[i], ca[i], cc[i]);
         m = hit(cd[i], w, cu[i], cl[i]);
         rchk(A_RSHI, {24'h0, w[15:8]});
         rchk(A_RSLO, {24'h0, w[7:0]});
         rchk(A_STAT, (32'(m) << `ADCW_ST_WIN) | (32'h1 << `ADCW_ST_DONE));
         chk({WINDOW_MATCH, IRQ}, {m, m});
      end
      // match, then a miss with no clear: the flag must hold
      conv(1'b0, 12'h400);
      conv(1'b0, 12'h050);
      chk(WINDOW_MATCH, 1'b1);
      apb(1'b1, A_IEN, 32'h0);
      @(posedge CLOCK);
      chk(IRQ, 1'b0);
      apb(1'b1, A_IEN, 32'h1 << `ADCW_ST_WIN);
      @(posedge CLOCK);
      chk(IRQ, 1'b1);
      apb(1'b1, A_ICLR, 32'h1 << `ADCW_ST_WIN);
      rchk(A_STAT, 32'h1 << `ADCW_ST_DONE);
      chk({WINDOW_MATCH, IRQ}, 2'b00);
      // a start while clock enable is low must not begin a conversion
      @(posedge CLOCK);
      CE <= 1'b0;
      CONV_START <= 1'b1;
      repeat (3) @(posedge CLOCK);
      chk(CONV_BUSY, 1'b0);
      CONV_START <= 1'b0;
      CE <= 1'b1;
      @(posedge CLOCK);
      report_and_stop();
   end
endmodule
